// file: logic/pds_pkg.sv
// Constants for the PWM dead-time and mask output stage
package pds_pkg;
   // Register bus geometry
   localparam int ADDR_W = 8;                 // Special-function address width
   localparam int DATA_W = 8;                 // Special-function data width
   localparam int PAGE_W = 2;                 // Register page select width

   // Register pages
   localparam logic [1:0] PAGE_MAIN = 2'h0;  // Page holding the dead-time and first masks
   localparam logic [1:0] PAGE_AUX  = 2'h2;  // Page holding masks of the other instances

   // Register offsets
   localparam logic [7:0] ADDR_PWM1_MASK_LEVEL  = 8'hAC;
   localparam logic [7:0] ADDR_PWM1_MASK_SELECT = 8'hAD;
   localparam logic [7:0] ADDR_PWM2_MASK_LEVEL  = 8'hBC;
   localparam logic [7:0] ADDR_PWM2_MASK_SELECT = 8'hBD;
   localparam logic [7:0] ADDR_PWM3_MASK_LEVEL  = 8'hCC;
   localparam logic [7:0] ADDR_PWM3_MASK_SELECT = 8'hCD;
   localparam logic [7:0] ADDR_DT_PAIR_ENABLE   = 8'hF9;
   localparam logic [7:0] ADDR_DT_COUNT_LOW     = 8'hFA;
   localparam logic [7:0] ADDR_PWM0_MASK_SELECT = 8'hFB;
   localparam logic [7:0] ADDR_PWM0_MASK_LEVEL  = 8'hFC;

   // Field layout of the dead-time enable register
   localparam int BIT_PAIR_A  = 0;            // Pair of channels 0 and 1
   localparam int BIT_PAIR_B  = 1;            // Pair of channels 2 and 3
   localparam int BIT_PAIR_C  = 2;            // Pair of channels 4 and 5
   localparam int BIT_DT_MSB  = 4;            // Bit 8 of the dead-time count

   // Channel counts
   localparam int CH0_N   = 6;                // Channels of the first instance
   localparam int CHX_N   = 2;                // Channels of each other instance
   localparam int PAIR_N  = 3;                // Complementary pairs of the first instance
   localparam int DT_W    = 9;                // Dead-time count width

   // Reset values
   localparam logic [7:0] RST_REG8    = 8'h00;
   localparam logic [8:0] RST_DT      = 9'h000;
   localparam logic [5:0] RST_MASK6   = 6'h00;
   localparam logic [1:0] RST_MASK2   = 2'h0;
   localparam logic [2:0] RST_PAIR    = 3'h0;
endpackage : pds_pkg

// file: logic/pds_pwm_deadtime_mask_stage.sv
// PWM output stage: dead-time insertion on complementary pairs and channel masking
//
// Behaviour
// - Dead-time count is low byte plus bit four
// - Pair enables delay rising edges of pairs
// - Pair enable ignored outside complementary mode
// - Count used only in complementary mode, enabled
// - Mask select chooses waveform or mask level
// - Masked output follows its mask level bit
// - Channels two to five masked only first instance
// - Dead-time registers writable only while unlocked
`timescale 1ns/100ps
module pds_pwm_deadtime_mask_stage
   import pds_pkg::*;
(
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              RESET_N,
   // Special-function register bus
   input  wire logic [ADDR_W-1:0] SFR_ADDR,
   input  wire logic [PAGE_W-1:0] SFR_PAGE,
   input  wire logic              SFR_WR,
   input  wire logic [DATA_W-1:0] SFR_WDATA,
   output logic      [DATA_W-1:0] SFR_RDATA,
   // Timed-access unlock state from the unlock unit
   input  wire logic              UNLOCK_OPEN,
   // Complementary-mode flags per pair of the first instance
   input  wire logic [PAIR_N-1:0] COMP_MODE,
   // Generator waveforms
   input  wire logic [CH0_N-1:0]  PWM0_GEN,
   input  wire logic [CHX_N-1:0]  PWM1_GEN,
   input  wire logic [CHX_N-1:0]  PWM2_GEN,
   input  wire logic [CHX_N-1:0]  PWM3_GEN,
   // Output pins
   output logic      [CH0_N-1:0]  PWM0_OUT,
   output logic      [CHX_N-1:0]  PWM1_OUT,
   output logic      [CHX_N-1:0]  PWM2_OUT,
   output logic      [CHX_N-1:0]  PWM3_OUT
);

   // Stored configuration
   logic [PAIR_N-1:0] pair_on_reg;            // Per-pair dead-time enables
   logic              dt_msb_reg;             // Bit 8 of the dead-time count
   logic [7:0]        dt_low_reg;             // Low byte of the dead-time count
   logic [CH0_N-1:0]  msel0_reg;              // First instance mask select
   logic [CH0_N-1:0]  mlvl0_reg;              // First instance mask level
   logic [5:0]        mselx_reg;              // Other instances mask select, two bits each
   logic [5:0]        mlvlx_reg;              // Other instances mask level, two bits each
   logic [DATA_W-1:0] rdata_reg;              // Registered read data

   // Full nine-bit dead-time count
   wire  [DT_W-1:0]   deadtime_count = {dt_msb_reg, dt_low_reg};

   // Address decode
   wire page_main = (SFR_PAGE == PAGE_MAIN);
   wire page_aux  = (SFR_PAGE == PAGE_AUX);
   wire hit_dten  = page_main && (SFR_ADDR == ADDR_DT_PAIR_ENABLE);
   wire hit_dtlo  = page_main && (SFR_ADDR == ADDR_DT_COUNT_LOW);
   wire hit_ms0   = page_main && (SFR_ADDR == ADDR_PWM0_MASK_SELECT);
   wire hit_ml0   = page_main && (SFR_ADDR == ADDR_PWM0_MASK_LEVEL);
   wire hit_ms1   = page_aux  && (SFR_ADDR == ADDR_PWM1_MASK_SELECT);
   wire hit_ml1   = page_aux  && (SFR_ADDR == ADDR_PWM1_MASK_LEVEL);
   wire hit_ms2   = page_aux  && (SFR_ADDR == ADDR_PWM2_MASK_SELECT);
   wire hit_ml2   = page_aux  && (SFR_ADDR == ADDR_PWM2_MASK_LEVEL);
   wire hit_ms3   = page_aux  && (SFR_ADDR == ADDR_PWM3_MASK_SELECT);
   wire hit_ml3   = page_aux  && (SFR_ADDR == ADDR_PWM3_MASK_LEVEL);

   // Protected writes need the unlock to be open
   wire wr_dten   = SFR_WR && hit_dten && UNLOCK_OPEN;
   wire wr_dtlo   = SFR_WR && hit_dtlo && UNLOCK_OPEN;

   // Next values of the mask registers of the other instances
   wire [5:0] mselx_next = {hit_ms3 ? SFR_WDATA[1:0] : mselx_reg[5:4],
                            hit_ms2 ? SFR_WDATA[1:0] : mselx_reg[3:2],
                            hit_ms1 ? SFR_WDATA[1:0] : mselx_reg[1:0]};
   wire [5:0] mlvlx_next = {hit_ml3 ? SFR_WDATA[1:0] : mlvlx_reg[5:4],
                            hit_ml2 ? SFR_WDATA[1:0] : mlvlx_reg[3:2],
                            hit_ml1 ? SFR_WDATA[1:0] : mlvlx_reg[1:0]};
   wire       wr_mx      = SFR_WR && (hit_ms1 || hit_ms2 || hit_ms3);
   wire       wr_lx      = SFR_WR && (hit_ml1 || hit_ml2 || hit_ml3);

   // Read multiplexer; reserved and missing bits read as zero
   wire [DATA_W-1:0] rd_dten = {3'h0, dt_msb_reg, 1'b0, pair_on_reg};
   wire [DATA_W-1:0] rdata_next =
      hit_dten ? rd_dten :
      hit_dtlo ? dt_low_reg :
      hit_ms0  ? {2'h0, msel0_reg} :
      hit_ml0  ? {2'h0, mlvl0_reg} :
      hit_ms1  ? {6'h00, mselx_reg[1:0]} :
      hit_ml1  ? {6'h00, mlvlx_reg[1:0]} :
      hit_ms2  ? {6'h00, mselx_reg[3:2]} :
      hit_ml2  ? {6'h00, mlvlx_reg[3:2]} :
      hit_ms3  ? {6'h00, mselx_reg[5:4]} :
      hit_ml3  ? {6'h00, mlvlx_reg[5:4]} :
      RST_REG8;                                 // Unmapped address reads zero

   // Dead-time enable register, unlock protected
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pair_on_reg <= RST_PAIR;
         dt_msb_reg  <= 1'b0;
      end else if (wr_dten) begin
         pair_on_reg <= {SFR_WDATA[BIT_PAIR_C], SFR_WDATA[BIT_PAIR_B], SFR_WDATA[BIT_PAIR_A]};
         dt_msb_reg  <= SFR_WDATA[BIT_DT_MSB];
      end
   end

   // Dead-time count low byte, unlock protected
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         dt_low_reg <= RST_REG8;
      end else if (wr_dtlo) begin
         dt_low_reg <= SFR_WDATA;
      end
   end

   // First instance mask registers, six channels
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         msel0_reg <= RST_MASK6;
         mlvl0_reg <= RST_MASK6;
      end else begin
         if (SFR_WR && hit_ms0) msel0_reg <= SFR_WDATA[CH0_N-1:0];
         if (SFR_WR && hit_ml0) mlvl0_reg <= SFR_WDATA[CH0_N-1:0];
      end
   end

   // Other instances keep only channels 0 and 1
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mselx_reg <= {RST_MASK2, RST_MASK2, RST_MASK2};
         mlvlx_reg <= {RST_MASK2, RST_MASK2, RST_MASK2};
      end else begin
         if (wr_mx) mselx_reg <= mselx_next;
         if (wr_lx) mlvlx_reg <= mlvlx_next;
      end
   end

   // Read data register, follows the address one cycle later
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) rdata_reg <= RST_REG8;
      else          rdata_reg <= rdata_next;
   end
   assign SFR_RDATA = rdata_reg;

   // First instance channels: dead-time then mask
   genvar gi;
   generate
      for (gi = 0; gi < CH0_N; gi++) begin : g_ch0
         logic [DT_W-1:0] cnt_reg;             // Cycles the waveform has been high
         logic            out_reg;             // Pin flop
         // Pair is delayed only with its enable set in complementary mode
         wire dt_active = pair_on_reg[gi/2] && COMP_MODE[gi/2];
         // Rising edge released once the count is reached
         wire cnt_done  = (cnt_reg == deadtime_count);
         wire delayed   = PWM0_GEN[gi] && (!dt_active || cnt_done);
         // Mask overrides after the delay stage
         wire out_next  = msel0_reg[gi] ? mlvl0_reg[gi] : delayed;

         // High-time counter, cleared while low, saturates at the count
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) begin
               cnt_reg <= RST_DT;
            end else if (!PWM0_GEN[gi]) begin  // Falling edge passes undelayed
               cnt_reg <= RST_DT;
            end else if (!cnt_done) begin
               cnt_reg <= cnt_reg + 9'h001;
            end
         end

         // Output pin flop
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) out_reg <= 1'b0;
            else          out_reg <= out_next;
         end
         assign PWM0_OUT[gi] = out_reg;
      end
   endgenerate

   // Other instances: mask only, no dead-time stage
   wire [5:0] genx = {PWM3_GEN, PWM2_GEN, PWM1_GEN};
   wire [5:0] outx;                             // Pin flops of instances 1 to 3
   generate
      for (gi = 0; gi < 6; gi++) begin : g_chx
         logic o_reg;                          // Pin flop, one per channel
         wire nxt = mselx_reg[gi] ? mlvlx_reg[gi] : genx[gi];
         always_ff @(posedge CLK or negedge RESET_N) begin
            if (!RESET_N) o_reg <= 1'b0;
            else          o_reg <= nxt;
         end
         assign outx[gi] = o_reg;
      end
   endgenerate
   assign PWM1_OUT = outx[1:0];
   assign PWM2_OUT = outx[3:2];
   assign PWM3_OUT = outx[5:4];

   // Checks on the stage behaviour
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   // Locked write leaves the dead-time enable register alone
   a_dt_locked_write: assert property (
      (SFR_WR && hit_dten && !UNLOCK_OPEN) |=> ($stable(pair_on_reg) && $stable(dt_msb_reg)))
      else $error("dead-time enable changed without unlock");

   // Unlocked write lands in the count low byte
   a_dt_open_write: assert property (
      (SFR_WR && hit_dtlo && UNLOCK_OPEN) |=> (dt_low_reg == $past(SFR_WDATA)))
      else $error("dead-time count write lost");

   // Bit four of the enable register reads back as the count top bit
   a_dt_msb_read: assert property (
      hit_dten |=> (SFR_RDATA[BIT_DT_MSB] == $past(deadtime_count[8]) && SFR_RDATA[7:5] == 3'h0))
      else $error("dead-time top bit readback wrong");

   // Masked channel shows its level on the next edge
   a_mask_level_out: assert property (
      msel0_reg[0] |=> (PWM0_OUT[0] == $past(mlvl0_reg[0])))
      else $error("masked output not at mask level");

   // Unmasked channel without active dead-time follows the generator
   a_pass_through: assert property (
      (!msel0_reg[2] && !(pair_on_reg[1] && COMP_MODE[1])) |=> (PWM0_OUT[2] == $past(PWM0_GEN[2])))
      else $error("output does not follow generator");

   // Falling edge is never delayed
   a_fall_nodelay: assert property (
      (!msel0_reg[0] && !PWM0_GEN[0]) |=> !PWM0_OUT[0])
      else $error("falling edge delayed");

   // Rising edge held low while the count runs
   a_rise_held: assert property (
      (!msel0_reg[0] && pair_on_reg[0] && COMP_MODE[0] && PWM0_GEN[0]
       && g_ch0[0].cnt_reg < deadtime_count) |=> !PWM0_OUT[0])
      else $error("rising edge released early");

   // Delay of three cycles released at its count
   a_rise_release: assert property (
      (!msel0_reg[2] && pair_on_reg[1] && COMP_MODE[1] && deadtime_count == 9'h003
       && $rose(PWM0_GEN[2])) ##0 (PWM0_GEN[2] && $stable(deadtime_count) && !msel0_reg[2]
       && pair_on_reg[1] && COMP_MODE[1])[*4] |=> PWM0_OUT[2])
      else $error("rising edge not released at count");

   // Second instance channels 2 to 5 do not exist
   a_inst1_narrow: assert property (
      hit_ms1 |=> (SFR_RDATA[7:2] == 6'h00))
      else $error("second instance reads high mask bits");

   // Second instance masked channel shows its level
   a_inst1_mask: assert property (
      mselx_reg[1] |=> (PWM1_OUT[1] == $past(mlvlx_reg[1])))
      else $error("second instance mask level wrong");

   // Locked write leaves the count low byte alone
   a_dt_low_locked: assert property (
      (SFR_WR && hit_dtlo && !UNLOCK_OPEN) |=> $stable(dt_low_reg))
      else $error("dead-time count changed without unlock");

   // Unlocked write lands in the enables of pairs A and C and the count top bit
   a_dt_en_write: assert property (
      (SFR_WR && hit_dten && UNLOCK_OPEN) |=> (dt_msb_reg == $past(SFR_WDATA[BIT_DT_MSB])
       && pair_on_reg[0] == $past(SFR_WDATA[BIT_PAIR_A])
       && pair_on_reg[2] == $past(SFR_WDATA[BIT_PAIR_C])))
      else $error("dead-time enable write lost");

   // Cleared pair enable passes the channel undelayed
   a_pair_off_pass: assert property (
      (!msel0_reg[1] && !pair_on_reg[0]) |=> (PWM0_OUT[1] == $past(PWM0_GEN[1])))
      else $error("disabled pair still delayed");

   // Mask wins over a pending dead-time delay
   a_mask_over_dt: assert property (
      (msel0_reg[0] && pair_on_reg[0] && COMP_MODE[0] && PWM0_GEN[0])
       |=> (PWM0_OUT[0] == $past(mlvl0_reg[0])))
      else $error("mask held back by dead-time");

   // First instance mask select takes six bits
   a_mask_sel_write: assert property (
      (SFR_WR && hit_ms0) |=> (msel0_reg == $past(SFR_WDATA[CH0_N-1:0])))
      else $error("mask select write lost");

   // Mask level write of the second instance keeps two bits
   a_inst1_lvl_write: assert property (
      (SFR_WR && hit_ml1) |=> (mlvlx_reg[1:0] == $past(SFR_WDATA[1:0])))
      else $error("second instance mask level write lost");

   // Other instances are never delayed
   a_inst2_nodelay: assert property (
      !mselx_reg[2] |=> (PWM2_OUT[0] == $past(PWM2_GEN[0])))
      else $error("third instance output does not follow generator");

   // Last instance masked channel shows its level
   a_inst3_mask: assert property (
      mselx_reg[5] |=> (PWM3_OUT[1] == $past(mlvlx_reg[5])))
      else $error("fourth instance mask level wrong");

   // Main scenarios
   c_dt_write:   cover property (SFR_WR && hit_dtlo && UNLOCK_OPEN);
   c_mask_dt:    cover property (msel0_reg[0] && pair_on_reg[0] && COMP_MODE[0] && PWM0_GEN[0]);
   c_rise_delay: cover property (pair_on_reg[0] && COMP_MODE[0] && !PWM0_OUT[0] && PWM0_GEN[0]
                                 ##1 PWM0_OUT[0]);
   c_masked_hi:  cover property (msel0_reg[5] && mlvl0_reg[5] ##1 PWM0_OUT[5]);
   c_locked:     cover property (SFR_WR && hit_dten && !UNLOCK_OPEN);

endmodule // pds_pwm_deadtime_mask_stage

// file: tb/pds_switch_driver.sv
// Behavioural model of the power-switch drivers that hang on the PWM pins
`timescale 1ns/100ps
module pds_switch_driver
   import pds_pkg::*;
(
   // Clock
   input  wire logic             clk,
   // Gate levels from the output pins
   input  wire logic [CH0_N-1:0] gate,
   // Switch state, one cycle behind the gate
   output logic      [CH0_N-1:0] switch_on
);
   // Switches follow their gate with one cycle of propagation
   always_ff @(posedge clk) begin
      switch_on <= gate;
   end
endmodule // pds_switch_driver

// file: tb/test_pwm_deadtime_mask_stage.sv
// Self-checking bench for the PWM dead-time and mask output stage
`timescale 1ns/100ps
module test_pwm_deadtime_mask_stage;
   import pds_pkg::*;
   logic             clk = 1'b0;           // System clock
   logic             rst_n = 1'b0;         // Reset, active low
   logic [7:0]       addr = 8'h00;         // Register address
   logic [7:0]       wdata = 8'h00;        // Write data
   logic [7:0]       rdata;                // Read data
   logic [1:0]       page = 2'h0;          // Register page
   logic             wr = 1'b0;            // Write strobe
   logic             unlock = 1'b0;        // Unlock open
   logic             look = 1'b0;          // A note is due now
   logic [2:0]       comp = 3'h0;          // Complementary mode per pair
   logic [5:0]       g0 = 6'h00;           // First instance waveforms
   logic [5:0]       gx = 6'h00;           // Other instances waveforms
   logic [5:0]       o0;                   // First instance pins
   logic [5:0]       ox;                   // Other instances pins
   logic [5:0]       sw;                   // Switch state of the model
   logic [15:0]      q[$];                 // Notes: selector and expected value
   logic [31:0]      seed = 32'he2b5_bf57; // Random state
   logic [7:0]       vals [10];            // Written register values
   logic [7:0]       l, m;                 // Scratch bytes
   logic [5:0]       a, b;                 // Scratch waveforms
   logic [8:0]       n;                    // Dead-time count under test
   int               err_count = 0;        // Mismatches
   int               tests_run = 0;        // Comparisons
   // Register table in a fixed order
   localparam logic [7:0] RA [10] = '{ADDR_PWM1_MASK_LEVEL, ADDR_PWM1_MASK_SELECT,
      ADDR_PWM2_MASK_LEVEL, ADDR_PWM2_MASK_SELECT, ADDR_PWM3_MASK_LEVEL,
      ADDR_PWM3_MASK_SELECT, ADDR_DT_PAIR_ENABLE, ADDR_DT_COUNT_LOW,
      ADDR_PWM0_MASK_SELECT, ADDR_PWM0_MASK_LEVEL};

   // Clock of 100 ns period
   always #50 clk = ~clk;

   // Design under test
   pds_pwm_deadtime_mask_stage u_pds_pwm_deadtime_mask_stage (
      .CLK(clk), .RESET_N(rst_n), .SFR_ADDR(addr), .SFR_PAGE(page), .SFR_WR(wr),
      .SFR_WDATA(wdata), .SFR_RDATA(rdata), .UNLOCK_OPEN(unlock), .COMP_MODE(comp),
      .PWM0_GEN(g0), .PWM1_GEN(gx[1:0]), .PWM2_GEN(gx[3:2]), .PWM3_GEN(gx[5:4]),
      .PWM0_OUT(o0), .PWM1_OUT(ox[1:0]), .PWM2_OUT(ox[3:2]), .PWM3_OUT(ox[5:4]));

   // Switch drivers on the first instance pins
   pds_switch_driver u_pds_switch_driver (.clk(clk), .gate(o0), .switch_on(sw));

   // Page and readable bits of each table entry
   function automatic logic [1:0] pg(int i);
      return (i < 6) ? PAGE_AUX : PAGE_MAIN;
   endfunction
   function automatic logic [7:0] rm(int i);
      return (i < 6) ? 8'h03 : (i == 6) ? 8'h17 : (i == 7) ? 8'hff : 8'h3f;
   endfunction
   // Xorshift random byte
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   // Compare and count
   task automatic chk(logic [7:0] seen, logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Note what the outputs must show after the next edge
   task automatic see(logic [7:0] sel, logic [7:0] exp);
      @(posedge clk);
      q.push_back({sel, exp});
      look <= 1'b1;
      @(negedge clk);
      #1 look <= 1'b0;
   endtask
   // One-cycle write strobe
   task automatic wr_reg(logic [1:0] p, logic [7:0] ad, logic [7:0] dt, logic t);
      @(posedge clk);
      page <= p;
      addr <= ad;
      wdata <= dt;
      wr <= 1'b1;
      unlock <= t;
      @(posedge clk);
      wr <= 1'b0;
      unlock <= 1'b0;
   endtask
   // Read data shows one edge after the address
   task automatic rd_reg(logic [1:0] p, logic [7:0] ad, logic [7:0] exp);
      @(posedge clk);
      page <= p;
      addr <= ad;
      see(8'h00, exp);
   endtask
   // Verdict and end of run
   task automatic wrap_up();
      if (err_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Monitor: takes the oldest note when one is due
   always @(negedge clk) begin
      if (look) begin
         case (q[0][15:8])
            8'h00:   chk(rdata, q[0][7:0]);
            8'h01:   chk({2'b00, o0}, q[0][7:0]);
            8'h03:   chk({2'b00, sw}, q[0][7:0]);
            default: chk({2'b00, ox}, q[0][7:0]);
         endcase
         q.pop_front();
      end
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      wrap_up();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, then an unmapped place
      for (int i = 0; i < 10; i++) rd_reg(pg(i), RA[i], 8'h00);
      rd_reg(PAGE_MAIN, 8'h80, 8'h00);
      // Random write and read-back of every register
      for (int i = 0; i < 10; i++) begin
         vals[i] = rnd();
         wr_reg(pg(i), RA[i], vals[i], 1'b1);
         rd_reg(pg(i), RA[i], vals[i] & rm(i));
      end
      // Locked writes to the dead-time registers are dropped
      for (int i = 6; i < 8; i++) begin
         wr_reg(PAGE_MAIN, RA[i], ~vals[i], 1'b0);
         rd_reg(PAGE_MAIN, RA[i], vals[i] & rm(i));
      end
      for (int i = 0; i < 10; i++) wr_reg(pg(i), RA[i], 8'h00, 1'b1);
      // Random mask selects and levels against random waveforms
      for (int k = 0; k < 6; k++) begin
         m = rnd();
         l = rnd();
         for (int i = 0; i < 10; i++) begin
            if (i != 6 && i != 7) begin
               wr_reg(pg(i), RA[i], (i == 9 || (i < 6 && i % 2 == 0)) ? l : m, 1'b0);
            end
         end
         @(posedge clk);
         a = 6'(rnd());
         b = 6'(rnd());
         g0 <= a;
         gx <= b;
         comp <= 3'(rnd());
         see(8'h01, {2'b00, (a & ~m[5:0]) | (l[5:0] & m[5:0])});
         see(8'h02, {2'b00, (b & ~{3{m[1:0]}}) | ({3{l[1:0]}} & {3{m[1:0]}})});
      end
      for (int i = 0; i < 10; i++) wr_reg(pg(i), RA[i], 8'h00, 1'b0);
      @(posedge clk);
      g0 <= 6'h00;
      comp <= 3'h7;
      // Dead time per pair, 9-bit count on the first pair
      for (int p = 0; p < 3; p++) begin
         n = (p == 0) ? 9'h103 : 9'(2 * p + 1);
         wr_reg(PAGE_MAIN, ADDR_DT_COUNT_LOW, n[7:0], 1'b1);
         wr_reg(PAGE_MAIN, ADDR_DT_PAIR_ENABLE, {3'h0, n[8], 1'b0, 3'(1 << p)}, 1'b1);
         a = 6'(6'h03 << (2 * p));
         @(posedge clk);
         comp <= 3'h7;
         g0 <= a;
         repeat (n - 1) @(posedge clk);
         see(8'h01, 8'h00);
         see(8'h01, {2'b00, a});
         see(8'h03, {2'b00, a});
         @(posedge clk);
         g0 <= 6'h00;
         see(8'h01, 8'h00);
         // Outside complementary mode the enable has no effect
         @(posedge clk);
         comp <= 3'h0;
         g0 <= a;
         see(8'h01, {2'b00, a});
         @(posedge clk);
         g0 <= 6'h00;
      end
      // Mask acts at once on a pair whose rising edge is still delayed
      wr_reg(PAGE_MAIN, ADDR_DT_PAIR_ENABLE, 8'h01, 1'b1);
      wr_reg(PAGE_MAIN, ADDR_PWM0_MASK_SELECT, 8'h01, 1'b0);
      wr_reg(PAGE_MAIN, ADDR_PWM0_MASK_LEVEL, 8'h01, 1'b0);
      @(posedge clk);
      comp <= 3'h7;
      g0 <= 6'h03;
      see(8'h01, 8'h01);
      repeat (4) @(posedge clk);
      wrap_up();
   end
endmodule // test_pwm_deadtime_mask_stage
